// File: src/asp_cfg.svh
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// Word and command framing on the serial link
`define ASP_WORD_W          24
`define ASP_CNT_W           5
`define ASP_CMD_BITS        5'd8
`define ASP_CMD_RD_BIT      6
`define ASP_ADDR_W          6

// Register addresses carried in the command byte
`define ASP_ADDR_STATUS     6'h00
`define ASP_ADDR_MODE       6'h01
`define ASP_ADDR_DATA       6'h04
`define ASP_ADDR_GPIO       6'h06

// Word lengths per register, in bits
`define ASP_BITS_STATUS     5'd8
`define ASP_BITS_CTRL       5'd16
`define ASP_BITS_DATA       5'd24
`define ASP_CTRL_W          16
`define ASP_STAT_W          8

// Reset values
`define ASP_MODE_RST        16'h0000
`define ASP_GPIO_RST        16'h0000
`define ASP_DATA_RST        24'h000000

// Field positions
`define ASP_GPIO_POWER_DOWN_SWITCH       14
`define ASP_GPIO_ERRMODE_HI 10
`define ASP_GPIO_ERRMODE_LO 9
`define ASP_GPIO_ERRDAT     8
`define ASP_MODE_CLKSEL_HI  3
`define ASP_MODE_CLKSEL_LO  2
`define ASP_STAT_RDY        7
`define ASP_STAT_ERR        6

// Timing
`define ASP_CLK_PERIOD_NS   8
`define ASP_RDY_GAP_NS      16
`define ASP_RDY_GAP_CYC     ((`ASP_RDY_GAP_NS + `ASP_CLK_PERIOD_NS - 1) \
                             / `ASP_CLK_PERIOD_NS)
`define ASP_GAP_W           4

// Buffering and crossing
`define ASP_FIFO_DEPTH      4
`define ASP_SYNC_W          5
`define ASP_SYNC_RST        5'h18
`define ASP_SY_WR           0
`define ASP_SY_RDDONE       1
`define ASP_SY_BUSY         2
`define ASP_SY_CS           3
`define ASP_SY_ERR          4

`endif

// File: src/asp_fifo.sv
`timescale 1ns/1ps

module asp_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [PW-1:0]    wrPtr;
   logic [PW-1:0]    rdPtr;
   logic [CW-1:0]    count;
   logic [PW-1:0]    next_wrPtr;
   logic [PW-1:0]    next_rdPtr;
   logic [CW-1:0]    next_count;
   logic             push;
   logic             pop;

   // Honest flags straight from the fill count
   assign inReady  = (count != CW'(DEPTH));
   assign outValid = (count != '0);
   assign outData  = mem[rdPtr];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Pointers wrap at DEPTH, so any depth works
   always_comb
   begin
      next_mem   = mem;
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      next_count = count;
      if (push)
      begin
         next_mem[wrPtr] = inData;
         next_wrPtr = (wrPtr == PW'(DEPTH - 1)) ? '0 : PW'(wrPtr + 1'b1);
      end
      if (pop)
         next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : PW'(rdPtr + 1'b1);
      if (push && !pop)
         next_count = CW'(count + 1'b1);
      else if (pop && !push)
         next_count = CW'(count - 1'b1);
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
      mem <= next_mem;
   end

endmodule

// File: src/asp_pkg.sv
`include "asp_cfg.svh"

package asp_pkg;

   // Error pin modes, in field order
   typedef enum logic [1:0] {ERR_OFF, ERR_IN, ERR_OD_OUT, ERR_GP_OUT}
      asp_errmode_type;

   // Clock source select, in field order
   typedef enum logic [1:0] {CLK_INT, CLK_INT_OUT, CLK_EXT_IN, CLK_XTAL}
      asp_clksel_type;

   // Role of the second crystal pin
   typedef enum logic [1:0] {XP_UNUSED, XP_CRYSTAL, XP_CLOCK_IN, XP_CLOCK_OUT}
      asp_xtalrole_type;

   // Link frame phase
   typedef enum logic [1:0] {PH_CMD, PH_WR, PH_RD} asp_phase_type;

   // Result update sequencer
   typedef enum logic {UPD_IDLE, UPD_GAP} asp_upd_type;

   // Word length of a register; unknown addresses take a byte
   function automatic logic [`ASP_CNT_W-1:0] asp_word_bits(
      input logic [`ASP_ADDR_W-1:0] addr);
      case (addr)
         `ASP_ADDR_DATA:   return `ASP_BITS_DATA;
         `ASP_ADDR_MODE,
         `ASP_ADDR_GPIO:   return `ASP_BITS_CTRL;
         default:          return `ASP_BITS_STATUS;
      endcase
   endfunction

endpackage

// File: src/asp_serial_port.sv
`timescale 1ns/1ps
`include "asp_cfg.svh"

//Function
// - Read-back bits change on the output pin at falling clock edges.
// - The serial output is released whenever the select input is high.
// - A read command loads the output shifter from any readable register.
// - Outside a register read the pin goes low once a new result is in.
// - An unread result lifts the ready level high before the next update.
// - Input bits are captured on rising edges of the host serial clock.
// - A finished input word goes to the mode or GPIO register named by the command.
// - Select may be tied low, framing then relies on bit counting alone.
// - In error input mode a low error pin sets the converter error flag.
// - The error pin offers error input, open-drain or plain output modes.
// - The power-down switch follows its bit in the GPIO configuration.
// - Clock select makes the crystal pin a crystal, clock in or out.
// - In open-drain mode the error pin is pulled low on any error bit.
// - In plain output mode the error pin drives its configured data bit.
module asp_serial_port
   import asp_pkg::*;
(
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic                   sclk,
   input  wire logic                   csN,
   input  wire logic                   din,
   output logic                        dout,
   output logic                        doutOe,
   input  wire logic                   resultValid,
   output logic                        resultReady,
   input  wire logic [`ASP_WORD_W-1:0] resultData,
   input  wire logic                   convErrorIn,
   input  wire logic                   errorPinIn,
   output logic                        errorPinOut,
   output logic                        errorPinOe,
   output logic                        powerDownSwitchClosed,
   output asp_xtalrole_type            crystalPinRole
);

   // Link side state
   asp_phase_type            phase;
   asp_phase_type            next_phase;
   logic [`ASP_CNT_W-1:0]    bitCnt;
   logic [`ASP_CNT_W-1:0]    next_bitCnt;
   logic [`ASP_WORD_W-1:0]   shiftIn;
   logic [`ASP_WORD_W-1:0]   next_shiftIn;
   logic [`ASP_ADDR_W-1:0]   cmdAddr;
   logic [`ASP_ADDR_W-1:0]   next_cmdAddr;
   logic                     busy;
   logic                     next_busy;
   logic [`ASP_ADDR_W-1:0]   wrAddr;
   logic [`ASP_ADDR_W-1:0]   next_wrAddr;
   logic [`ASP_WORD_W-1:0]   wrData;
   logic [`ASP_WORD_W-1:0]   next_wrData;
   logic                     wrToggle;
   logic                     next_wrToggle;
   logic                     rdDoneToggle;
   logic                     next_rdDoneToggle;
   logic [`ASP_WORD_W-1:0]   outShift;
   logic [`ASP_WORD_W-1:0]   next_outShift;
   logic [`ASP_WORD_W-1:0]   cmdWord;
   logic [`ASP_CNT_W-1:0]    wordBits;
   logic                     frameRst;
   logic                     linkRstReq;
   logic                     next_linkRstReq;

   // System side state
   logic [`ASP_SYNC_W-1:0]   syncIn;
   logic [`ASP_SYNC_W-1:0]   syncOut;
   logic                     wrSeen;
   logic                     rdDoneSeen;
   logic                     next_wrSeen;
   logic                     next_rdDoneSeen;
   logic                     wrEvt;
   logic                     rdDoneEvt;
   logic [`ASP_CTRL_W-1:0]   modeReg;
   logic [`ASP_CTRL_W-1:0]   next_modeReg;
   logic [`ASP_CTRL_W-1:0]   gpioReg;
   logic [`ASP_CTRL_W-1:0]   next_gpioReg;
   asp_upd_type              updState;
   asp_upd_type              next_updState;
   logic [`ASP_GAP_W-1:0]    gapCnt;
   logic [`ASP_GAP_W-1:0]    next_gapCnt;
   logic [`ASP_WORD_W-1:0]   dataReg;
   logic [`ASP_WORD_W-1:0]   next_dataReg;
   logic                     unread;
   logic                     next_unread;
   logic                     rdyN;
   logic                     next_rdyN;
   logic                     pop;
   logic                     fifoValid;
   logic [`ASP_WORD_W-1:0]   fifoData;
   logic                     statusErr;
   logic                     next_statusErr;
   logic                     next_doutOe;
   logic                     next_errorPinOut;
   logic                     next_errorPinOe;
   logic                     next_power_down_switch;
   asp_xtalrole_type         next_role;
   asp_errmode_type          errMode;
   asp_clksel_type           clkSel;
   logic [`ASP_STAT_W-1:0]   statusWord;
   logic [`ASP_WORD_W-1:0]   readWord;

   // Frame logic is cleared by a high select or by system reset
   assign frameRst = csN | linkRstReq;

   always_comb
   begin
      next_linkRstReq = sys_rst;
   end

   always_ff @(posedge clock)
   begin
      linkRstReq <= next_linkRstReq;
   end

   // Command byte, then a data word of the addressed register's length
   always_comb
   begin
      next_shiftIn      = {shiftIn[`ASP_WORD_W-2:0], din};
      next_phase        = phase;
      next_bitCnt       = `ASP_CNT_W'(bitCnt + 1'b1);
      next_cmdAddr      = cmdAddr;
      next_wrAddr       = wrAddr;
      next_wrData       = wrData;
      next_wrToggle     = wrToggle;
      next_rdDoneToggle = rdDoneToggle;
      cmdWord           = next_shiftIn;
      wordBits          = asp_word_bits(cmdAddr);
      unique case (phase)
         PH_CMD:
         begin
            if (bitCnt == `ASP_CNT_W'(`ASP_CMD_BITS - 1'b1))
            begin
               next_cmdAddr = cmdWord[`ASP_ADDR_W-1:0];
               next_phase   = cmdWord[`ASP_CMD_RD_BIT] ? PH_RD : PH_WR;
               next_bitCnt  = '0;
            end
         end
         PH_WR,
         PH_RD:
         begin
            if (bitCnt == `ASP_CNT_W'(wordBits - 1'b1))
            begin
               next_phase  = PH_CMD;
               next_bitCnt = '0;
               if (phase == PH_WR)
               begin
                  next_wrAddr   = cmdAddr;
                  next_wrData   = cmdWord;
                  next_wrToggle = ~wrToggle;
               end
               else if (cmdAddr == `ASP_ADDR_DATA)
                  next_rdDoneToggle = ~rdDoneToggle;
            end
         end
      endcase
      next_busy = (next_phase != PH_CMD) || (next_bitCnt != '0);
   end

   // Tied-low select leaves only the system reset to frame words
   always_ff @(posedge sclk or posedge frameRst)
   begin
      if (frameRst)
      begin
         phase   <= PH_CMD;
         bitCnt  <= '0;
         shiftIn <= '0;
         cmdAddr <= '0;
         busy    <= 1'b0;
      end
      else
      begin
         phase   <= next_phase;
         bitCnt  <= next_bitCnt;
         shiftIn <= next_shiftIn;
         cmdAddr <= next_cmdAddr;
         busy    <= next_busy;
      end
   end

   // Toggles survive a select pulse, else the far side sees a false event
   always_ff @(posedge sclk or posedge linkRstReq)
   begin
      if (linkRstReq)
      begin
         wrToggle     <= 1'b0;
         rdDoneToggle <= 1'b0;
         wrAddr       <= '0;
         wrData       <= '0;
      end
      else
      begin
         wrToggle     <= next_wrToggle;
         rdDoneToggle <= next_rdDoneToggle;
         wrAddr       <= next_wrAddr;
         wrData       <= next_wrData;
      end
   end

   // Readable registers; the data register is frozen by the busy level while a word goes out
   always_comb
   begin
      statusWord                = '0;
      statusWord[`ASP_STAT_RDY] = rdyN;
      statusWord[`ASP_STAT_ERR] = statusErr;
      case (cmdAddr)
         `ASP_ADDR_STATUS: readWord = {16'h0000, statusWord};
         `ASP_ADDR_MODE:   readWord = {8'h00, modeReg};
         `ASP_ADDR_GPIO:   readWord = {8'h00, gpioReg};
         `ASP_ADDR_DATA:   readWord = dataReg;
         default:          readWord = '0;
      endcase
   end

   // Load left-aligned on the first falling edge, then shift out
   always_comb
   begin
      if (phase == PH_RD && bitCnt == '0)
         next_outShift = `ASP_WORD_W'(readWord <<
                         (`ASP_BITS_DATA - asp_word_bits(cmdAddr)));
      else
         next_outShift = {outShift[`ASP_WORD_W-2:0], 1'b0};
   end

   always_ff @(negedge sclk or posedge frameRst)
   begin
      if (frameRst)
         outShift <= '0;
      else
         outShift <= next_outShift;
   end

   // Pin shows read data during a read, the ready level otherwise
   assign dout = (phase == PH_RD) ? outShift[`ASP_WORD_W-1]
                                  : rdyN;

   // Link toggles, the busy level, select and the error pin cross two flops
   assign syncIn[`ASP_SY_WR]     = wrToggle;
   assign syncIn[`ASP_SY_RDDONE] = rdDoneToggle;
   assign syncIn[`ASP_SY_BUSY]   = busy;
   assign syncIn[`ASP_SY_CS]     = csN;
   assign syncIn[`ASP_SY_ERR]    = errorPinIn;

   asp_sync #(
      .WIDTH   (`ASP_SYNC_W),
      .RST_VAL (`ASP_SYNC_RST)
   ) u_sync (
      .clock   (clock),
      .sys_rst (sys_rst),
      .async   (syncIn),
      .synced  (syncOut)
   );

   assign wrEvt     = syncOut[`ASP_SY_WR] ^ wrSeen;
   assign rdDoneEvt = syncOut[`ASP_SY_RDDONE] ^ rdDoneSeen;

   // Apply written words; read-only and unknown addresses are dropped
   always_comb
   begin
      next_wrSeen     = syncOut[`ASP_SY_WR];
      next_rdDoneSeen = syncOut[`ASP_SY_RDDONE];
      next_modeReg    = modeReg;
      next_gpioReg    = gpioReg;
      if (wrEvt)
      begin
         if (wrAddr == `ASP_ADDR_MODE)
            next_modeReg = wrData[`ASP_CTRL_W-1:0];
         else if (wrAddr == `ASP_ADDR_GPIO)
            next_gpioReg = wrData[`ASP_CTRL_W-1:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         wrSeen     <= 1'b0;
         rdDoneSeen <= 1'b0;
         modeReg    <= `ASP_MODE_RST;
         gpioReg    <= `ASP_GPIO_RST;
      end
      else
      begin
         wrSeen     <= next_wrSeen;
         rdDoneSeen <= next_rdDoneSeen;
         modeReg    <= next_modeReg;
         gpioReg    <= next_gpioReg;
      end
   end

   // Results queue here; a busy link stalls the drain and fills the queue
   asp_fifo #(
      .WIDTH    (`ASP_WORD_W),
      .DEPTH    (`ASP_FIFO_DEPTH)
   ) u_fifo (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .inValid  (resultValid),
      .inReady  (resultReady),
      .inData   (resultData),
      .outValid (fifoValid),
      .outReady (pop),
      .outData  (fifoData)
   );

   // Result update with a high gap when the old result went unread
   always_comb
   begin
      next_updState = updState;
      next_gapCnt   = gapCnt;
      next_dataReg  = dataReg;
      next_unread   = unread;
      next_rdyN     = rdyN;
      pop           = 1'b0;
      if (gapCnt != '0)
         next_gapCnt = `ASP_GAP_W'(gapCnt - 1'b1);
      if (rdDoneEvt)
      begin
         next_unread = 1'b0;
         next_rdyN   = 1'b1;
      end
      unique case (updState)
         UPD_IDLE:
         begin
            if (fifoValid && !syncOut[`ASP_SY_BUSY])
            begin
               if (unread && !rdDoneEvt)
               begin
                  next_rdyN     = 1'b1;
                  next_gapCnt   = `ASP_GAP_W'(`ASP_RDY_GAP_CYC - 1);
                  next_updState = UPD_GAP;
               end
               else
                  pop = 1'b1;
            end
         end
         UPD_GAP:
         begin
            if (gapCnt == '0 && fifoValid && !syncOut[`ASP_SY_BUSY])
               pop = 1'b1;
         end
      endcase
      // New result wins over a clear in the same cycle
      if (pop)
      begin
         next_dataReg  = fifoData;
         next_unread   = 1'b1;
         next_rdyN     = 1'b0;
         next_updState = UPD_IDLE;
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         updState <= UPD_IDLE;
         gapCnt   <= '0;
         dataReg  <= `ASP_DATA_RST;
         unread   <= 1'b0;
         rdyN     <= 1'b1;
      end
      else
      begin
         updState <= next_updState;
         gapCnt   <= next_gapCnt;
         dataReg  <= next_dataReg;
         unread   <= next_unread;
         rdyN     <= next_rdyN;
      end
   end

   // Pin control decoded from the configuration registers
   assign errMode = asp_errmode_type'(
                    gpioReg[`ASP_GPIO_ERRMODE_HI:`ASP_GPIO_ERRMODE_LO]);
   assign clkSel  = asp_clksel_type'(
                    modeReg[`ASP_MODE_CLKSEL_HI:`ASP_MODE_CLKSEL_LO]);

   always_comb
   begin
      next_doutOe    = ~syncOut[`ASP_SY_CS];
      next_statusErr = convErrorIn ||
                       (errMode == ERR_IN && !syncOut[`ASP_SY_ERR]);
      next_power_down_switch      = gpioReg[`ASP_GPIO_POWER_DOWN_SWITCH];
      next_errorPinOut = 1'b0;
      next_errorPinOe  = 1'b0;
      unique case (errMode)
         ERR_OFF,
         ERR_IN:     next_errorPinOe = 1'b0;
         ERR_OD_OUT: next_errorPinOe = statusErr;
         ERR_GP_OUT:
         begin
            next_errorPinOut = gpioReg[`ASP_GPIO_ERRDAT];
            next_errorPinOe  = 1'b1;
         end
      endcase
      unique case (clkSel)
         CLK_INT:     next_role = XP_UNUSED;
         CLK_INT_OUT: next_role = XP_CLOCK_OUT;
         CLK_EXT_IN:  next_role = XP_CLOCK_IN;
         CLK_XTAL:    next_role = XP_CRYSTAL;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         doutOe                <= 1'b0;
         statusErr             <= 1'b0;
         powerDownSwitchClosed <= 1'b0;
         errorPinOut           <= 1'b0;
         errorPinOe            <= 1'b0;
         crystalPinRole        <= XP_UNUSED;
      end
      else
      begin
         doutOe                <= next_doutOe;
         statusErr             <= next_statusErr;
         powerDownSwitchClosed <= next_power_down_switch;
         errorPinOut           <= next_errorPinOut;
         errorPinOe            <= next_errorPinOe;
         crystalPinRole        <= next_role;
      end
   end

endmodule

// File: src/asp_sync.sv
`timescale 1ns/1ps

module asp_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async,
   output logic      [WIDTH-1:0] synced
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_synced;

   // First stage feeds only the second one
   always_comb
   begin
      next_stage1 = async;
      next_synced = stage1;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         stage1 <= RST_VAL;
         synced <= RST_VAL;
      end
      else
      begin
         stage1 <= next_stage1;
         synced <= next_synced;
      end
   end

endmodule

// File: test/asp_host_model.sv
`timescale 1ns/1ps
// Serial master; its clock only runs inside frames
module asp_host_model (
   output logic      sclk,
   output logic      csN,
   output logic      din,
   input  wire logic dout,
   input  wire logic doutOe
);
   initial
   begin
      sclk = 1'b1;
      csN = 1'b1;
      din = 1'b0;
   end
   // Command then n data bits, most significant first
   task automatic frame(input logic [7:0] c, input logic [23:0] d,
      input int n, output logic [23:0] rd);
      logic [31:0] sh;
      sh = {c, d << (24 - n)};
      rd = 24'h000000;
      csN = 1'b0;
      #20;
      for (int i = 0; i < 8 + n; i++)
      begin
         sclk = 1'b0;
         din = sh[31];
         sh = sh << 1;
         #7.5 sclk = 1'b1;
         if (i >= 8)
            rd = {rd[22:0], doutOe ? dout : ~rd[0]};
         #7.5;
      end
      din = ~din; // Flipped data line shows no stale bit
   endtask
endmodule

// File: test/asp_serial_port_monitor.sv
`timescale 1ns/1ps
// Port-level checks beside the serial port
module asp_serial_port_monitor
   import asp_pkg::*;
(
   input wire logic             clock,
   input wire logic             sys_rst,
   input wire logic             csN,
   input wire logic             doutOe,
   input wire logic             resultValid,
   input wire logic             resultReady,
   input wire logic             errorPinOut,
   input wire logic             errorPinOe,
   input wire logic             powerDownSwitchClosed,
   input wire asp_xtalrole_type crystalPinRole
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Select held long enough for the sync chain
   sequence selOff;
      csN[*5];
   endsequence
   sequence selOn;
      !csN[*5];
   endsequence
   chk_sel_off: assert property (selOff |-> !doutOe)
      else $error("output driven while deselected");
   chk_sel_on: assert property (selOn |-> doutOe)
      else $error("output idle while selected");
   chk_oe_rise: assert property ($rose(doutOe) |->
      !$past(csN, 2) || !$past(csN, 3) || !$past(csN, 4))
      else $error("enable rose without select");
   chk_oe_fall: assert property ($fell(doutOe) |->
      $past(csN, 2) || $past(csN, 3) || $past(csN, 4))
      else $error("enable fell while selected");
   chk_err_drive: assert property (errorPinOut |-> errorPinOe)
      else $error("error pin high but undriven");
   chk_fifo_full: assert property ($fell(resultReady) |->
      $past(resultValid))
      else $error("buffer filled without a push");
   chk_power_down_switch_hold: assert property ($changed(powerDownSwitchClosed)
      |=> $stable(powerDownSwitchClosed)[*3])
      else $error("switch toggled without a write");
   chk_role_hold: assert property ($changed(crystalPinRole)
      |=> $stable(crystalPinRole)[*3])
      else $error("pin role toggled without a write");
endmodule

// File: test/test_asp_serial_port.sv
`timescale 1ns/1ps
module test_asp_serial_port;
   import asp_pkg::*;
   logic             clock, sys_rst, sclk, csN, din, dout, doutOe, hi;
   logic             resultValid, resultReady, convErrorIn, errLow;
   logic             errorPinIn, errorPinOut, errorPinOe;
   logic             powerDownSwitchClosed;
   logic [23:0]      resultData, rd, w;
   asp_xtalrole_type crystalPinRole;
   int               failures, cmp_count, cycles;
   logic [23:0]      resQ[$];
   asp_xtalrole_type roleOf[4] = '{XP_UNUSED, XP_CLOCK_OUT,
      XP_CLOCK_IN, XP_CRYSTAL};
   // Pulled-up pin that another device may pull low
   assign errorPinIn = (errorPinOe ? errorPinOut : 1'b1) & ~errLow;
   asp_serial_port u_asp_serial_port (.clock(clock), .sys_rst(sys_rst),
      .sclk(sclk), .csN(csN), .din(din), .dout(dout), .doutOe(doutOe),
      .resultValid(resultValid), .resultReady(resultReady),
      .resultData(resultData), .convErrorIn(convErrorIn),
      .errorPinIn(errorPinIn), .errorPinOut(errorPinOut),
      .errorPinOe(errorPinOe), .crystalPinRole(crystalPinRole),
      .powerDownSwitchClosed(powerDownSwitchClosed));
   asp_host_model u_asp_host_model (.sclk(sclk), .csN(csN), .din(din),
      .dout(dout), .doutOe(doutOe));
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Bound on the whole run
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Frame, then room for the crossing to settle
   task automatic xf(input logic [7:0] c, input logic [23:0] d, input int n);
      u_asp_host_model.frame(c, d, n, rd);
      repeat (8) @(negedge clock);
   endtask
   task automatic push(input logic [23:0] d);
      @(negedge clock);
      resultValid = 1'b1;
      resultData = d;
      @(posedge clock);
      while (resultReady !== 1'b1)
         @(posedge clock);
      @(negedge clock);
      resultValid = 1'b0;
      resQ.push_back(d);
   endtask
   task automatic waitLow();
      for (int i = 0; i < 40 && dout !== 1'b0; i++)
         @(negedge clock);
   endtask
   initial
   begin
      sys_rst = 1'b1;
      resultValid = 1'b0;
      resultData = 24'h000000;
      convErrorIn = 1'b0;
      errLow = 1'b0;
      void'($urandom(32'hcec7c408));
      repeat (5) @(negedge clock);
      chk(doutOe, 1'b0);
      chk(crystalPinRole, XP_UNUSED);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      // Every clock select code, written and read back
      for (int m = 0; m < 4; m++)
      begin
         w = 24'(m << 2);
         xf(8'h01, w, 16);
         chk(crystalPinRole, roleOf[m]);
         xf(8'h41, 24'h000000, 16);
         chk(rd, w);
      end
      // Every error pin mode with random switch and data bits
      for (int e = 0; e < 4; e++)
      begin
         w = 24'($urandom) & 24'h004100 | 24'(e << 9);
         convErrorIn = (e == 2);
         errLow = (e == 1);
         xf(8'h06, w, 16);
         chk(powerDownSwitchClosed, w[14]);
         chk(errorPinOe, e >= 2);
         chk(errorPinOut, e == 3 && w[8]);
         xf(8'h40, 24'h000000, 8);
         chk(rd[6], e == 1 || e == 2);
         xf(8'h46, 24'h000000, 16);
         chk(rd, w);
      end
      errLow = 1'b0;
      // New result flags ready; a read clears it
      push(24'($urandom));
      waitLow();
      chk(dout, 1'b0);
      xf(8'h44, 24'h000000, 24);
      chk(rd, resQ.pop_front());
      chk(dout, 1'b1);
      // Unread result: ready lifts before the next update lands
      push(24'($urandom));
      waitLow();
      push(24'($urandom));
      hi = 1'b0;
      repeat (20)
      begin
         @(negedge clock);
         hi |= dout;
      end
      chk(hi, 1'b1);
      chk(dout, 1'b0);
      void'(resQ.pop_front());
      xf(8'h44, 24'h000000, 24);
      chk(rd, resQ.pop_front());
      // Read left hanging after its command: updates stall, queue fills
      xf(8'h44, 24'h000000, 0);
      repeat (4) push(24'($urandom));
      chk(resultReady, 1'b0);
      u_asp_host_model.csN = 1'b1;
      repeat (20) @(negedge clock);
      chk(doutOe, 1'b0);
      repeat (3) void'(resQ.pop_front());
      xf(8'h44, 24'h000000, 24);
      chk(rd, resQ.pop_front());
      chk(resultReady, 1'b1);
      u_asp_host_model.csN = 1'b1;
      repeat (6) @(negedge clock);
      chk(doutOe, 1'b0);
      complete_run();
   end
endmodule
bind asp_serial_port asp_serial_port_monitor u_mon (.clock(clock),
   .sys_rst(sys_rst), .csN(csN), .doutOe(doutOe),
   .resultValid(resultValid), .resultReady(resultReady),
   .errorPinOut(errorPinOut), .errorPinOe(errorPinOe),
   .powerDownSwitchClosed(powerDownSwitchClosed),
   .crystalPinRole(crystalPinRole));
